// ---- dv/single_wire_master_bit_io_tb.sv ----
// Purpose: Self-checking bench for the single-wire master
// Assumes: Shortened reset and presence counts, slot counts kept wide enough
// Notes:   Token answers are chosen per operation by the bench
`timescale 1ns/1ps
`default_nettype none

module single_wire_master_bit_io_tb;
    localparam int P_PWIN  = 20;
    localparam int P_PMIN  = 20;   // Presence bounds keep the window's ratios
    localparam int P_PMAX  = 80;
    localparam int P_ALARM = 400;
    localparam int P_SHORT = 1600; // Four times the alarm limit

    logic                 clk_in   = 1'b0;
    logic                 rst_n_in = 1'b0;
    logic                 start    = 1'b0;
    swm_pkg::swm_op_t     kind     = swm_pkg::swm_bit_op;
    logic [7:0]           wdata    = 8'h00;
    logic                 irq_en   = 1'b0;
    logic                 irq_clr  = 1'b0;
    logic [1:0]           mode     = 2'h3;
    logic [7:0]           tx       = 8'hFF;
    logic [19:0]          dly      = 20'h00000;
    logic [19:0]          len      = 20'h00000;
    logic                 restart  = 1'b0;
    logic                 arrive   = 1'b0;
    wire                  line;
    logic                 bus_o, bus_oe, busy, done, irq, armed, pull;
    swm_pkg::swm_result_t result;
    logic [7:0]           rx;
    logic [10:0]          res;
    int                   error_cnt    = 0;
    int                   total_checks = 0;
    logic [1:0]           t_mode [7] = '{2'h1, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h1};
    int                   t_dly  [7] = '{10, 10, 21, 0, 0, 0, 10};
    int                   t_len  [7] = '{19, 81, 40, 0, 1700, 500, 40};

    // Wired-AND line with pull-up
    assign line = (bus_oe ? bus_o : 1'b1) & ~pull;

    always #2 clk_in = ~clk_in;

    swm_master #(
        .LOW0_CYC(20'h00FA0), .SLOT_CYC(20'h01194), .RST_CYC(20'h000C8),
        .PRES_WIN_CYC(20'h00014), .ALARM_CYC(20'h00190)
    ) u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .op_start_in(start), .op_kind_in(kind),
        .op_wdata_in(wdata), .irq_en_in(irq_en), .irq_clr_in(irq_clr), .bus_in(line),
        .bus_out(bus_o), .bus_oe_out(bus_oe), .op_busy_out(busy), .op_done_out(done),
        .result_out(result), .irq_out(irq), .alarm_armed_out(armed)
    );

    swm_token_model u_tok (
        .clk_in(clk_in), .line_in(line), .mode_in(mode), .tx_byte_in(tx), .dly_in(dly),
        .len_in(len), .restart_in(restart), .arrive_in(arrive), .pull_out(pull),
        .rx_byte_out(rx)
    );

    ////////////////////////////////////////
    task automatic check(input string nm, input logic [10:0] exp, input logic [10:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic results();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // Expected reset outcome from the token's low pulse
    function automatic logic [10:0] exp_rst(input logic [1:0] m, input int d, input int l);
        logic [10:0] e;
        e = 11'h000;
        if (m == 2'h2 && l >= P_SHORT) e[8] = 1'b1;
        else if (m == 2'h2 && l >= P_ALARM) e[10:9] = 2'h3;
        else if (m == 2'h1) e[10] = (d <= P_PWIN) && (l >= P_PMIN) && (l <= P_PMAX);
        return e;
    endfunction : exp_rst

    task automatic prep(input logic [1:0] m, input logic [7:0] t, input int d, input int l);
        @(posedge clk_in);
        mode    <= m;
        tx      <= t;
        dly     <= 20'(d);
        len     <= 20'(l);
        restart <= 1'b1;
        @(posedge clk_in);
        restart <= 1'b0;
    endtask : prep

    // One start pulse, bounded wait for done, result taken in the done cycle
    task automatic run_op(input swm_pkg::swm_op_t k, input logic [7:0] wd);
        int n;
        @(posedge clk_in);
        start <= 1'b1;
        kind  <= k;
        wdata <= wd;
        @(posedge clk_in);
        start <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (done !== 1'b1 && n < 40000);
        check("done_busy", 11'h002, {9'h000, done, busy});
        res = result;
    endtask : run_op

    // Hang guard well beyond the planned run length
    initial begin
        repeat (90000) @(posedge clk_in);
        error_cnt++;
        results();
    end

    ////////////////////////////////////////
    initial begin
        logic [10:0] e;
        logic [7:0]  wd;
        logic [7:0]  tv;
        void'($urandom(6));
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        check("reset_outputs", 11'h000, {6'h00, bus_oe, busy, done, irq, armed});
        check("reset_result", 11'h000, result);
        // Arrival edge flagged, cleared, then ignored while disabled
        prep(2'h3, 8'hFF, 0, 50);
        irq_en <= 1'b1;
        arrive <= 1'b1;
        @(posedge clk_in);
        arrive <= 1'b0;
        repeat (10) @(negedge clk_in);
        check("irq_arrival", 11'h001, {10'h000, irq});
        @(posedge clk_in);
        irq_clr <= 1'b1;
        @(posedge clk_in);
        irq_clr <= 1'b0;
        @(negedge clk_in);
        check("irq_cleared", 11'h000, {10'h000, irq});
        repeat (60) @(posedge clk_in);
        irq_en <= 1'b0;
        arrive <= 1'b1;
        @(posedge clk_in);
        arrive <= 1'b0;
        repeat (60) @(negedge clk_in);
        check("irq_disabled", 11'h000, {10'h000, irq});
        // Reset cases: short, long, late, none, short circuit, alarm, valid
        t_dly[6] = $urandom_range(P_PWIN, 1);
        t_len[6] = $urandom_range(P_PMAX, P_PMIN);
        for (int i = 0; i < 7; i++) begin
            prep(t_mode[i], 8'hFF, t_dly[i], t_len[i]);
            run_op(swm_pkg::swm_reset_presence_op, 8'h00);
            e = exp_rst(t_mode[i], t_dly[i], t_len[i]);
            check("reset_op_result", e, res);
            check("armed_after_reset", {10'h000, e[10]}, {10'h000, armed});
            repeat (300) @(negedge clk_in);
            check("irq_while_disabled", 11'h000, {10'h000, irq});
        end
        // Bit slots; first one writes one against a token answering zero
        @(posedge clk_in);
        irq_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wd = (i == 0) ? 8'h01 : 8'($urandom);
            tv = (i == 0) ? 8'hFE : 8'($urandom);
            prep(2'h0, tv, 0, 0);
            run_op(swm_pkg::swm_bit_op, wd);
            check("bit_result", {10'h000, wd[0] & tv[0]}, res);
            check("bit_on_wire", {10'h000, wd[0] & tv[0]}, {10'h000, rx[0] & tv[0]});
            check("armed_cleared", 11'h000, {10'h000, armed});
            check("irq_own_edges", 11'h000, {10'h000, irq});
        end
        // Byte with a start attempted mid-transfer
        wd = 8'hEC;
        tv = 8'($urandom);
        prep(2'h0, tv, 0, 0);
        fork
            run_op(swm_pkg::swm_byte_op, wd);
            begin
                repeat (100) @(posedge clk_in);
                start <= 1'b1;
                @(posedge clk_in);
                start <= 1'b0;
                @(negedge clk_in);
                check("busy_refused", 11'h001, {10'h000, busy});
            end
        join
        check("byte_result", {3'h0, wd & tv}, res);
        check("byte_on_wire", {3'h0, wd & tv}, {3'h0, rx & tv});
        repeat (100) @(negedge clk_in);
        check("result_held", {3'h0, wd & tv}, result);
        results();
    end
endmodule : single_wire_master_bit_io_tb

`default_nettype wire

// ---- dv/swm_token_model.sv ----
// Purpose: Behavioural token on the far side of the single-wire line
// Assumes: Bench picks the response mode before each operation
// Notes:   Times are counted in clk_in cycles; the model only ever pulls low
`timescale 1ns/1ps
`default_nettype none

module swm_token_model (
    input  wire logic        clk_in,
    input  wire logic        line_in,
    input  wire logic [1:0]  mode_in,
    input  wire logic [7:0]  tx_byte_in,
    input  wire logic [19:0] dly_in,
    input  wire logic [19:0] len_in,
    input  wire logic        restart_in,
    input  wire logic        arrive_in,
    output logic             pull_out,
    output logic [7:0]       rx_byte_out
);
    logic       pull_s = 1'b0;
    logic       pull_a = 1'b0;
    logic [2:0] idx    = 3'h0;
    logic       tb;

    // Released line returns to the pull-up level
    assign pull_out = pull_s | pull_a;

    // Bit index restarts for each new transfer
    always @(posedge restart_in) begin
        idx = 3'h0;
    end

    // Spontaneous arrival pulse on first contact
    always @(posedge arrive_in) begin
        pull_a <= 1'b1;
        repeat (len_in) @(posedge clk_in);
        pull_a <= 1'b0;
    end

    ////////////////////////////////////////
    // Answers to master activity; 0 slot, 1 presence, 2 hold low, 3 silent
    always @(negedge line_in) begin
        if (mode_in == 2'h0) begin
            tb = tx_byte_in[idx];
            pull_s <= ~tb;
            repeat (2750) @(posedge clk_in);
            if (tb) rx_byte_out[idx] = line_in;
            // Held past the master's sample point, freed before slot end
            repeat (1450) @(posedge clk_in);
            pull_s <= 1'b0;
            idx = idx + 3'h1;
        end else if (mode_in == 2'h1) begin
            @(posedge line_in);
            repeat (dly_in) @(posedge clk_in);
            pull_s <= 1'b1;
            repeat (len_in) @(posedge clk_in);
            pull_s <= 1'b0;
        end else if (mode_in == 2'h2) begin
            pull_s <= 1'b1;
            repeat (len_in) @(posedge clk_in);
            pull_s <= 1'b0;
        end
    end
endmodule : swm_token_model

`default_nettype wire

// ---- hw/swm_master.sv ----
// Purpose: Single-wire bus master: bit slots, bytes, reset/presence, edge irq
// Assumes: Open-drain line with pull-up; one operation at a time
// Notes:   Long counts are parameters so simulation can shorten them
// Contract
// (RL1) Every bit slot sends one bit and returns the sampled line bit.
// (RL2) A byte is eight back-to-back bit slots, least significant bit first.
// (RL3) A falling edge not caused by the master raises an interrupt request.
// (RL4) A newly attached token pulses low on its own, announcing arrival.
// (RL5) Edges are only flagged while edge detection is enabled.
// (RL6) A token signals alarm only if the last activity was reset/presence.
// (RL7) Alarm reception needs the edge enable plus a prior reset on the bus.
// (RL8) After an alarm the host reads the token's function registers.
// (RL9) With many tokens the host prefers the conditional alarm search.
// (RL10) Presence is a low pulse starting within 60 us, lasting 60..240 us.
// (RL11) Low from 960 us to under 3840 us flags alarm with presence true.
// (RL12) Low for 3840 us or more flags a short with presence false.
// (RL13) The line is only pulled low and own edges are kept from the irq.
// (RL14) Operations use one start/done handshake; results hold until next.
`timescale 1ns/1ps
`default_nettype none

module swm_master #(
    parameter logic [19:0] LOW0_CYC     = swm_pkg::LOW0_CYC,
    parameter logic [19:0] SLOT_CYC     = swm_pkg::SLOT_CYC,
    parameter logic [19:0] RST_CYC      = swm_pkg::RST_CYC,
    parameter logic [19:0] PRES_WIN_CYC = swm_pkg::PRES_WIN_CYC,
    parameter logic [19:0] PRES_MIN_CYC = 20'(PRES_WIN_CYC * swm_pkg::T_PRES_MIN_US
                                              / swm_pkg::T_PRES_WIN_US),
    parameter logic [19:0] PRES_MAX_CYC = 20'(PRES_WIN_CYC * swm_pkg::T_PRES_MAX_US
                                              / swm_pkg::T_PRES_WIN_US),
    parameter logic [19:0] ALARM_CYC    = swm_pkg::ALARM_CYC,
    parameter logic [19:0] SHORT_CYC    = 20'(ALARM_CYC * swm_pkg::T_SHORT_US
                                              / swm_pkg::T_ALARM_US)
) (
    input  wire logic            clk_in,
    input  wire logic            rst_n_in,
    input  wire logic            op_start_in,
    input  wire swm_pkg::swm_op_t op_kind_in,
    input  wire logic [7:0]      op_wdata_in,
    input  wire logic            irq_en_in,
    input  wire logic            irq_clr_in,
    input  wire logic            bus_in,
    output logic                 bus_out,
    output logic                 bus_oe_out,
    output logic                 op_busy_out,
    output logic                 op_done_out,
    output swm_pkg::swm_result_t result_out,
    output logic                 irq_out,
    output logic                 alarm_armed_out
);

    ////////////////////////////////////////////////////////////////////////
    // State and storage
    swm_pkg::swm_state_t  st_ff, nxt_st;
    swm_pkg::swm_op_t     kind_ff;
    swm_pkg::swm_result_t res_ff, nxt_res;
    logic [19:0]          tot_ff;
    logic [19:0]          ph_ff;
    logic [7:0]           sh_ff;
    logic [3:0]           bits_ff;
    logic [3:0]           slots_ff;
    logic [2:0]           busy_hist_ff;
    logic                 rx_ff, oe_ff, busy_ff, done_ff, irq_ff, arm_ff;
    logic                 line_w, fall_w;

    swm_sync_fall u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (bus_in),
        .lvl_out  (line_w),
        .fall_out (fall_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode of timing events
    wire        idle_w    = (st_ff == swm_pkg::S_IDLE);
    wire        start_ok  = op_start_in && idle_w;
    wire        in_slot   = (st_ff == swm_pkg::S_BIT_LOW) || (st_ff == swm_pkg::S_BIT_REL);
    wire [19:0] low_len   = sh_ff[0] ? swm_pkg::LOW1_CYC : LOW0_CYC;
    wire        low_end   = (st_ff == swm_pkg::S_BIT_LOW) && (tot_ff == low_len - 20'h1);
    wire        slot_end  = in_slot && (tot_ff == SLOT_CYC - 20'h1);
    wire        samp      = in_slot && (tot_ff == swm_pkg::SAMP_CYC);
    wire        last_bit  = (bits_ff == swm_pkg::ONE_BIT);
    wire        rst_rel   = (st_ff == swm_pkg::S_RST_LOW) && (tot_ff == RST_CYC - 20'h1);
    wire        in_rise   = (st_ff == swm_pkg::S_RST_RISE);
    wire        in_pulse  = (st_ff == swm_pkg::S_RST_PULSE);
    wire        in_pwait  = (st_ff == swm_pkg::S_RST_PWAIT);
    wire        rst_alarm = in_rise && line_w && (tot_ff >= ALARM_CYC);             // RL11
    wire        rst_early = in_rise && line_w && (tot_ff < ALARM_CYC);
    wire        rst_short = (in_rise || in_pulse) && !line_w
                            && (tot_ff >= SHORT_CYC - 20'h1);                       // RL12
    wire        pw_none   = in_pwait && line_w && (ph_ff >= PRES_WIN_CYC - 20'h1);
    wire        pw_fall   = in_pwait && !line_w;
    wire        pulse_end = in_pulse && line_w;
    wire        pres_ok   = (ph_ff >= PRES_MIN_CYC - 20'h1) && (ph_ff < PRES_MAX_CYC); // RL10
    wire        op_fin    = (slot_end && last_bit) || rst_alarm || rst_short
                            || pw_none || pulse_end;
    wire        is_byte   = (kind_ff == swm_pkg::swm_byte_op);
    wire        is_rst    = (kind_ff == swm_pkg::swm_reset_presence_op);
    wire        mask_w    = busy_ff || (|busy_hist_ff);                             // RL13
    wire        irq_set   = fall_w && irq_en_in && !mask_w;                     // RL3 RL4 RL5
    wire [7:0]  sh_next   = {rx_ff, sh_ff[7:1]};                                    // RL2

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            swm_pkg::S_IDLE: begin
                if (start_ok) begin
                    nxt_st = (op_kind_in == swm_pkg::swm_reset_presence_op)
                             ? swm_pkg::S_RST_LOW : swm_pkg::S_BIT_LOW;
                end
            end
            swm_pkg::S_BIT_LOW: begin
                if (low_end) begin
                    nxt_st = swm_pkg::S_BIT_REL;
                end
            end
            swm_pkg::S_BIT_REL: begin
                if (slot_end) begin
                    nxt_st = last_bit ? swm_pkg::S_IDLE : swm_pkg::S_BIT_LOW;      // RL2
                end
            end
            swm_pkg::S_RST_LOW: begin
                if (rst_rel) begin
                    nxt_st = swm_pkg::S_RST_RISE;
                end
            end
            swm_pkg::S_RST_RISE: begin
                if (rst_alarm || rst_short) begin
                    nxt_st = swm_pkg::S_IDLE;
                end else if (rst_early) begin
                    nxt_st = swm_pkg::S_RST_PWAIT;
                end
            end
            swm_pkg::S_RST_PWAIT: begin
                if (pw_none) begin
                    nxt_st = swm_pkg::S_IDLE;
                end else if (pw_fall) begin
                    nxt_st = swm_pkg::S_RST_PULSE;
                end
            end
            swm_pkg::S_RST_PULSE: begin
                if (pulse_end || rst_short) begin
                    nxt_st = swm_pkg::S_IDLE;
                end
            end
            default: nxt_st = swm_pkg::S_IDLE;
        endcase
    end

    // Result assembly at the end of an operation
    always_comb begin
        nxt_res           = res_ff;
        nxt_res.presence  = 1'b0;
        nxt_res.alarm     = 1'b0;
        nxt_res.short_ckt = 1'b0;
        nxt_res.data      = 8'h00;
        if (is_rst) begin
            nxt_res.presence  = rst_alarm || (pulse_end && pres_ok);               // RL10 RL11
            nxt_res.alarm     = rst_alarm;
            nxt_res.short_ckt = rst_short;                                          // RL12
        end else if (is_byte) begin
            nxt_res.data = sh_next;                                                 // RL2
        end else begin
            nxt_res.data = {7'h00, rx_ff};                                          // RL1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Engine registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff   <= swm_pkg::S_IDLE;
            kind_ff <= swm_pkg::swm_bit_op;
            tot_ff  <= 20'h00000;
            ph_ff   <= 20'h00000;
            oe_ff   <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            kind_ff <= start_ok ? op_kind_in : kind_ff;
            tot_ff  <= (start_ok || slot_end) ? 20'h00000 : tot_ff + 20'h1;
            ph_ff   <= (nxt_st != st_ff) ? 20'h00000 : ph_ff + 20'h1;
            oe_ff   <= (nxt_st == swm_pkg::S_BIT_LOW) || (nxt_st == swm_pkg::S_RST_LOW); // RL13
            busy_ff <= (nxt_st != swm_pkg::S_IDLE);
        end
    end

    // Bit shifting and sampling, LSB out first
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sh_ff    <= 8'h00;
            bits_ff  <= 4'h0;
            rx_ff    <= 1'b1;
            slots_ff <= 4'h0;
        end else begin
            rx_ff <= samp ? line_w : rx_ff;                                         // RL1
            if (start_ok) begin
                sh_ff    <= op_wdata_in;
                bits_ff  <= (op_kind_in == swm_pkg::swm_byte_op)
                            ? swm_pkg::BYTE_BITS : swm_pkg::ONE_BIT;                // RL2
                slots_ff <= 4'h0;
            end else if (slot_end) begin
                sh_ff    <= sh_next;
                bits_ff  <= bits_ff - 4'h1;
                slots_ff <= slots_ff + 4'h1;
            end
        end
    end

    // Handshake, result hold, edge irq and alarm arming
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_ff       <= swm_pkg::RES_RST;
            done_ff      <= 1'b0;
            irq_ff       <= 1'b0;
            arm_ff       <= 1'b0;
            busy_hist_ff <= 3'h0;
        end else begin
            res_ff       <= op_fin ? nxt_res : res_ff;                              // RL14
            done_ff      <= op_fin;                                                 // RL14
            irq_ff       <= irq_set || (irq_ff && !irq_clr_in);                     // RL3
            busy_hist_ff <= {busy_hist_ff[1:0], busy_ff};
            // Tokens only alarm after reset/presence; any slot disarms them
            if (op_fin && is_rst) begin
                arm_ff <= nxt_res.presence;                                         // RL7 RL6
            end else if (start_ok && (op_kind_in != swm_pkg::swm_reset_presence_op)) begin
                arm_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign bus_out         = 1'b0;  // Open drain: only ever pulls low
    assign bus_oe_out      = oe_ff;
    assign op_busy_out     = busy_ff;
    assign op_done_out     = done_ff;
    assign result_out      = res_ff;
    assign irq_out         = irq_ff;
    assign alarm_armed_out = arm_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_bit_start;
        idle_w && op_start_in && (op_kind_in != swm_pkg::swm_reset_presence_op);
    endsequence
    sequence s_drive_low;
        bus_oe_out && op_busy_out;
    endsequence

    property p_slot_drives;
        s_bit_start |=> s_drive_low;
    endproperty
    a_slot_drives: assert property (p_slot_drives) else $error("slot not driven"); // RL1

    property p_byte_eight;
        (op_fin && is_byte) |-> (slots_ff == 4'h7) && slot_end;
    endproperty
    a_byte_eight: assert property (p_byte_eight) else $error("byte not 8 slots"); // RL2

    property p_irq_unmasked;
        (fall_w && irq_en_in && !mask_w) |=> irq_out;
    endproperty
    a_irq_unmasked: assert property (p_irq_unmasked) else $error("edge lost"); // RL3

    property p_irq_enabled;
        $rose(irq_out) |-> $past(irq_en_in) && !$past(mask_w);
    endproperty
    a_irq_enabled: assert property (p_irq_enabled) else $error("irq when off"); // RL5

    property p_oe_only_busy;
        bus_oe_out |-> op_busy_out && !op_done_out;
    endproperty
    a_oe_only_busy: assert property (p_oe_only_busy) else $error("stray drive"); // RL13

    property p_done_pulse;
        op_done_out |=> !op_done_out && (op_busy_out == $past(op_start_in));
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse"); // RL14

    property p_result_hold;
        !$past(op_fin) |-> $stable(result_out);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved"); // RL14

    property p_short_no_pres;
        (op_done_out && result_out.short_ckt) |-> !result_out.presence;
    endproperty
    a_short_no_pres: assert property (p_short_no_pres) else $error("short with presence"); // RL12

    property p_alarm_pres;
        (op_done_out && result_out.alarm) |-> result_out.presence && alarm_armed_out;
    endproperty
    a_alarm_pres: assert property (p_alarm_pres) else $error("alarm w/o presence"); // RL11

endmodule : swm_master

`default_nettype wire

// ---- hw/swm_pkg.sv ----
// Purpose: Shared constants and types for the single-wire master bit engine
// Assumes: 250 MHz system clock, open-drain bus with external pull-up
// Notes:   Times are kept in microseconds, cycle counts derived from them
package swm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timer geometry
    localparam int CLK_MHZ = 250;
    localparam int TMR_W   = 20;
    localparam int GUARD_W = 3;

    ////////////////////////////////////////////////////////////////////////
    // Times in microseconds
    localparam int T_LOW1_US     = 6;     // Short low pulse: write one / read
    localparam int T_SAMP_US     = 15;    // Sample point within a slot
    localparam int T_LOW0_US     = 60;    // Long low pulse: write zero
    localparam int T_SLOT_US     = 70;    // Whole slot including recovery
    localparam int T_RST_US      = 480;   // Reset low time
    localparam int T_PRES_WIN_US = 60;    // Presence must start within this
    localparam int T_PRES_MIN_US = 60;    // Shortest valid presence pulse
    localparam int T_PRES_MAX_US = 240;   // Longest valid presence pulse
    localparam int T_ALARM_US    = 960;   // Continuous low: alarm pending
    localparam int T_SHORT_US    = 3840;  // Continuous low: short circuit

    ////////////////////////////////////////////////////////////////////////
    // Cycle counts (all exact at 250 MHz)
    localparam logic [TMR_W-1:0] LOW1_CYC     = TMR_W'(T_LOW1_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] SAMP_CYC     = TMR_W'(T_SAMP_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] LOW0_CYC     = TMR_W'(T_LOW0_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] SLOT_CYC     = TMR_W'(T_SLOT_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] RST_CYC      = TMR_W'(T_RST_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] PRES_WIN_CYC = TMR_W'(T_PRES_WIN_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] PRES_MIN_CYC = TMR_W'(T_PRES_MIN_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] PRES_MAX_CYC = TMR_W'(T_PRES_MAX_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] ALARM_CYC    = TMR_W'(T_ALARM_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] SHORT_CYC    = TMR_W'(T_SHORT_US * CLK_MHZ);

    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] ONE_BIT   = 4'h1;

    ////////////////////////////////////////////////////////////////////////
    // Operation kinds
    typedef enum logic [1:0] {
        swm_bit_op            = 2'h0,
        swm_byte_op           = 2'h1,
        swm_reset_presence_op = 2'h2
    } swm_op_t;

    // Engine states, one-hot
    typedef enum logic [6:0] {
        S_IDLE      = 7'h01,
        S_BIT_LOW   = 7'h02,
        S_BIT_REL   = 7'h04,
        S_RST_LOW   = 7'h08,
        S_RST_RISE  = 7'h10,
        S_RST_PWAIT = 7'h20,
        S_RST_PULSE = 7'h40
    } swm_state_t;

    // Result of one operation
    typedef struct packed {
        logic       presence;
        logic       alarm;
        logic       short_ckt;
        logic [7:0] data;
    } swm_result_t;

    localparam swm_result_t RES_RST = '0;

endpackage : swm_pkg

// ---- hw/swm_sync_fall.sv ----
// Purpose: Two-flop synchroniser for the bus line with falling-edge detect
// Assumes: Input is asynchronous to clk_in
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module swm_sync_fall (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic d_in,
    output logic      lvl_out,
    output logic      fall_out
);

    logic meta_ff;
    logic lvl_ff;
    logic prev_ff;

    ////////////////////////////////////////////////////////////////////////
    // Idle bus reads high, so reset to one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= 1'b1;
            lvl_ff  <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= d_in;
            lvl_ff  <= meta_ff;
            prev_ff <= lvl_ff;
        end
    end

    // Edge taken from settled stages only
    assign lvl_out  = lvl_ff;
    assign fall_out = prev_ff & ~lvl_ff;

endmodule : swm_sync_fall

`default_nettype wire
